// >>> src/dgp_gpio.sv
// dual gpio port with change detection on the upper second-port bits
//
// Overview of operation
// - five-bit first port, per-bit direction
// - direction 1 releases pin, 0 drives latch
// - reads return pins, writes load latch
// - writes replace the whole latch, pins not sampled
// - bit 4 timer clock in, open-drain low
// - bits 3..0 digital or analog by config
// - reset: bits 3..0 analog, read as zero
// - direction still gates drivers in analog mode
// - ccp, timer oscillator and programming enables override direction of bits 3, 2..1 and 6
// - only upper input bits join change detect
// - compare upper inputs with last-access copy
// - mismatches ORed into flag bit 0
// - port change raises wake request
// - any second-port data access refreshes comparison copy
// - switchable pull-ups, bit 0 external interrupt
// - bit 3 capture/compare/pwm pin
// - bits 6,7 serial programming clock/data
// - bit 1 timer osc out/clock, bit 2 osc in
// - timer on main clock leaves pins alone
// - counter clock: pin, firmware bit, oscillator
module dgp_gpio (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // first port pins
  input  wire logic [4:0] portAIn,
  output logic      [4:0] portAOut,
  output logic      [4:0] portAOe,
  output logic      [3:0] analogSel,
  output logic            firstTimerClk,
  // second port pins
  input  wire logic [7:0] portBIn,
  output logic      [7:0] portBOut,
  output logic      [7:0] portBOe,
  output logic      [7:0] portBPullup,
  // peripheral side
  input  wire logic       ccpDrive,
  input  wire logic       timerOscOut,
  output logic            extIntPin,
  output logic            ccpPinLevel,
  output logic            secondTimerClk,
  output logic            progClk,
  output logic            progData,
  output logic            wakeReq
);
  // ***********************************
  // reset release
  // ***********************************
  logic rstSync1_q;
  logic rstSync2_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  logic rstnInt;
  assign rstnInt = rstSync2_q;

  // ***********************************
  // register state
  // ***********************************
  logic [4:0] aLatch_q;
  logic [4:0] aLatch_d;
  logic [4:0] aDir_q;
  logic [4:0] aDir_d;
  logic [7:0] bLatch_q;
  logic [7:0] bLatch_d;
  logic [7:0] bDir_q;
  logic [7:0] bDir_d;
  logic [3:0] analog_q;
  logic [3:0] analog_d;
  logic [7:0] pullup_q;
  logic [7:0] pullup_d;
  logic [7:0] periph_q;
  logic [7:0] periph_d;
  logic       fwClk_q;
  logic       fwClk_d;
  logic       wakeEn_q;
  logic       wakeEn_d;
  // copy of the upper second-port bits at the last access
  logic [3:0] oldB_q;
  logic [3:0] oldB_d;
  logic       flag_q;
  logic       flag_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // pin views as software sees them
  logic [4:0] aView;
  logic [7:0] bView;
  logic       ccpOn;
  logic       ccpOut;
  logic       tmrCnt;
  logic       tmrOsc;
  logic       progOn;
  logic [3:0] mismatch;
  logic [7:0] bDirEff;

  assign ccpOn  = periph_q[dgp_pkg::CCP_EN_BIT];
  assign ccpOut = periph_q[dgp_pkg::CCP_OUT_BIT];
  assign tmrCnt = periph_q[dgp_pkg::TMR_CNT_BIT];
  assign tmrOsc = periph_q[dgp_pkg::TMR_OSC_BIT] & tmrCnt;
  assign progOn = periph_q[dgp_pkg::PROG_EN_BIT];

  always_comb begin
    // analog pins read zero
    aView = portAIn & {1'b1, ~analog_q};
    bView = portBIn;
    // capture on input: reads zero while ccp owns the pin
    if (ccpOn && bDir_q[3]) begin
      bView[3] = 1'b0;
    end
    // compare/pwm: pin is peripheral-driven, read shows latch
    if (ccpOn && !bDir_q[3]) begin
      bView[3] = bLatch_q[3];
    end
  end

  // direction as the pins see it, peripherals take over
  always_comb begin
    bDirEff = bDir_q;
    if (ccpOn) begin
      bDirEff[3] = ~ccpOut;
    end
    if (tmrOsc) begin
      bDirEff[2:1] = 2'h3;
    end
    if (progOn) begin
      bDirEff[6] = 1'b1;
    end
  end

  // ***********************************
  // change detect, one comparator per upper bit
  // ***********************************
  // outputs drop out so their own drive never trips the flag
  for (genvar g = 0; g < 4; g++) begin : gChange
    assign mismatch[g] = (portBIn[4 + g] ^ oldB_q[g]) & bDir_q[4 + g];
  end

  // ***********************************
  // register next state
  // ***********************************
  always_comb begin
    aLatch_d = aLatch_q;
    aDir_d   = aDir_q;
    bLatch_d = bLatch_q;
    bDir_d   = bDir_q;
    analog_d = analog_q;
    pullup_d = pullup_q;
    periph_d = periph_q;
    fwClk_d  = fwClk_q;
    wakeEn_d = wakeEn_q;
    if (regWr) begin
      unique case (regAddr)
        dgp_pkg::ADDR_A_DATA: aLatch_d = regWdata[4:0];
        dgp_pkg::ADDR_A_DIR:  aDir_d   = regWdata[4:0];
        dgp_pkg::ADDR_B_DATA: bLatch_d = regWdata;
        dgp_pkg::ADDR_B_DIR:  bDir_d   = regWdata;
        dgp_pkg::ADDR_ANALOG: analog_d = regWdata[3:0];
        dgp_pkg::ADDR_PULLUP: pullup_d = regWdata;
        dgp_pkg::ADDR_PERIPH: periph_d = regWdata;
        dgp_pkg::ADDR_FWDATA: fwClk_d  = regWdata[dgp_pkg::FW_CLK_BIT];
        dgp_pkg::ADDR_INTCTL: wakeEn_d = regWdata[dgp_pkg::WAKE_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      aLatch_q <= 5'h00;
      aDir_q   <= dgp_pkg::RST_A_DIR;
      bLatch_q <= 8'h00;
      bDir_q   <= dgp_pkg::RST_B_DIR;
      analog_q <= dgp_pkg::RST_ANALOG;
      pullup_q <= dgp_pkg::RST_PULLUP;
      periph_q <= 8'h00;
      fwClk_q  <= 1'b0;
      wakeEn_q <= 1'b0;
    end else begin
      aLatch_q <= aLatch_d;
      aDir_q   <= aDir_d;
      bLatch_q <= bLatch_d;
      bDir_q   <= bDir_d;
      analog_q <= analog_d;
      pullup_q <= pullup_d;
      periph_q <= periph_d;
      fwClk_q  <= fwClk_d;
      wakeEn_q <= wakeEn_d;
    end
  end

  // ***********************************
  // read data, stands one cycle after the strobe
  // ***********************************
  always_comb begin
    // idle and unmapped reads give zero
    rdata_d = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        dgp_pkg::ADDR_A_DATA: rdata_d = {3'h0, aView};
        dgp_pkg::ADDR_A_DIR:  rdata_d = {3'h0, aDir_q};
        dgp_pkg::ADDR_B_DATA: rdata_d = bView;
        dgp_pkg::ADDR_B_DIR:  rdata_d = bDir_q;
        dgp_pkg::ADDR_ANALOG: rdata_d = {4'h0, analog_q};
        dgp_pkg::ADDR_PULLUP: rdata_d = pullup_q;
        dgp_pkg::ADDR_PERIPH: rdata_d = periph_q;
        dgp_pkg::ADDR_FWDATA: rdata_d = {7'h00, fwClk_q};
        dgp_pkg::ADDR_INTCTL: rdata_d = {6'h00, wakeEn_q, flag_q};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ***********************************
  // change flag and comparison copy
  // ***********************************
  // strobes that touch the change logic
  logic portBHit;
  logic flagClr;
  assign portBHit = (regWr || regRd) && regAddr == dgp_pkg::ADDR_B_DATA;
  assign flagClr  = regWr && regAddr == dgp_pkg::ADDR_INTCTL && !regWdata[dgp_pkg::CHG_FLAG_BIT];

  always_comb begin
    oldB_d = oldB_q;
    flag_d = flag_q;
    if (flagClr) begin
      flag_d = 1'b0;
    end
    // any read or write of the second-port data refreshes the copy
    if (portBHit) begin
      oldB_d = portBIn[7:4];
    end else if (|mismatch) begin
      // set beats a same-cycle clear, but a change seen during a port access is dropped
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      oldB_q <= 4'h0;
      flag_q <= 1'b0;
    end else begin
      oldB_q <= oldB_d;
      flag_q <= flag_d;
    end
  end

  // ***********************************
  // pin drivers, registered
  // ***********************************
  logic [4:0] aOut_d;
  logic [4:0] aOe_d;
  logic [4:0] aOut_q;
  logic [4:0] aOe_q;
  logic [7:0] bOut_d;
  logic [7:0] bOe_d;
  logic [7:0] bOut_q;
  logic [7:0] bOe_q;
  logic       tClk_d;
  logic       tClk_q;
  logic [5:0] side_d;
  logic [5:0] side_q;

  // first port, one slice per bit
  for (genvar g = 0; g < 5; g++) begin : gPortA
    if (g == dgp_pkg::OD_BIT) begin : gOpenDrain
      // never drives high, so the shared timer clock line cannot fight it
      assign aOut_d[g] = 1'b0;
      assign aOe_d[g]  = ~aDir_q[g] & ~aLatch_q[g];
    end else begin : gPushPull
      // analog mode keeps the driver; software must hold the pin an input
      assign aOut_d[g] = aLatch_q[g];
      assign aOe_d[g]  = ~aDir_q[g];
    end
  end

  always_comb begin
    bOut_d = bLatch_q;
    bOe_d  = ~bDirEff;
    // ccp owns bit 3 data, its direction comes from bDirEff
    if (ccpOn) begin
      bOut_d[3] = ccpDrive;
    end
    // oscillator output takes bit 1 whatever its direction bit says
    if (tmrOsc) begin
      bOut_d[1] = timerOscOut;
      bOe_d[1]  = 1'b1;
    end
  end

  // port data and drive-enable outputs come straight from these flops
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      aOut_q <= 5'h00;
      aOe_q  <= 5'h00;
      bOut_q <= 8'h00;
      bOe_q  <= 8'h00;
    end else begin
      aOut_q <= aOut_d;
      aOe_q  <= aOe_d;
      bOut_q <= bOut_d;
      bOe_q  <= bOe_d;
    end
  end

  // ***********************************
  // peripheral side copies and counter clock
  // ***********************************
  always_comb begin
    unique case (periph_q[dgp_pkg::TMR_SRC_LSB +: 2])
      dgp_pkg::SRC_FW:  tClk_d = fwClk_q;
      dgp_pkg::SRC_OSC: tClk_d = portBIn[2];
      default:          tClk_d = portBIn[1];
    endcase
    // timer on the main clock: no pin reaches the counter
    if (!tmrCnt) begin
      tClk_d = 1'b0;
    end
    // copies lag the pins by one clock, like the port drivers; analogSel and portBPullup come straight from their registers
    side_d = {flag_q & wakeEn_q, portBIn[7], portBIn[6], portBIn[3], portBIn[0], portAIn[dgp_pkg::OD_BIT]};
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      tClk_q <= 1'b0;
      side_q <= 6'h00;
    end else begin
      tClk_q <= tClk_d;
      side_q <= side_d;
    end
  end

  assign regRdata       = rdata_q;
  assign portAOut       = aOut_q;
  assign portAOe        = aOe_q;
  assign analogSel      = analog_q;
  assign firstTimerClk  = side_q[0];
  assign portBOut       = bOut_q;
  assign portBOe        = bOe_q;
  assign portBPullup    = pullup_q;
  assign extIntPin      = side_q[1];
  assign ccpPinLevel    = side_q[2];
  assign progClk        = side_q[3];
  assign progData       = side_q[4];
  assign wakeReq        = side_q[5];
  assign secondTimerClk = tClk_q;
endmodule

// >>> src/dgp_pkg.sv
// constants for the dual gpio port block
package dgp_pkg;
  // register offsets (word index on the plain register port)
  localparam logic [3:0] ADDR_A_DATA  = 4'h0;
  localparam logic [3:0] ADDR_A_DIR   = 4'h1;
  localparam logic [3:0] ADDR_B_DATA  = 4'h2;
  localparam logic [3:0] ADDR_B_DIR   = 4'h3;
  localparam logic [3:0] ADDR_ANALOG  = 4'h4;
  localparam logic [3:0] ADDR_PULLUP  = 4'h5;
  localparam logic [3:0] ADDR_INTCTL  = 4'h6;
  localparam logic [3:0] ADDR_PERIPH  = 4'h7;
  localparam logic [3:0] ADDR_FWDATA  = 4'h8;
  // field positions
  localparam int OD_BIT        = 4;
  localparam int CHG_FLAG_BIT  = 0;
  localparam int WAKE_BIT      = 1;
  localparam int CCP_EN_BIT    = 0;
  localparam int CCP_OUT_BIT   = 1;
  localparam int CCP_LVL_BIT   = 2;
  localparam int TMR_CNT_BIT   = 3;
  localparam int TMR_OSC_BIT   = 4;
  localparam int TMR_SRC_LSB   = 5;
  localparam int PROG_EN_BIT   = 7;
  localparam int FW_CLK_BIT    = 0;
  // timer clock sources in counter mode
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_FW  = 2'h1;
  localparam logic [1:0] SRC_OSC = 2'h2;
  // reset values
  localparam logic [4:0] RST_A_DIR   = 5'h1f;
  localparam logic [7:0] RST_B_DIR   = 8'hff;
  localparam logic [3:0] RST_ANALOG  = 4'hf;
  localparam logic [7:0] RST_PULLUP  = 8'h00;
endpackage

// >>> sim/dgp_board.sv
// board model that resolves the port pin levels
module dgp_board (
  // pins from the block
  input  wire logic [4:0] portAOut,
  input  wire logic [4:0] portAOe,
  input  wire logic [7:0] portBOut,
  input  wire logic [7:0] portBOe,
  input  wire logic [7:0] portBPullup,
  // board drive
  input  wire logic [4:0] extA,
  input  wire logic [7:0] extB,
  // pin levels
  output logic      [4:0] portAIn,
  output logic      [7:0] portBIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // released lines follow the board, pulled-up ones go high
  assign portAIn = (portAOe & portAOut) | (~portAOe & extA);
  assign portBIn = (portBOe & portBOut) | (~portBOe & (portBPullup | extB));
endmodule

// >>> sim/dgp_gpio_props.sv
// port-level checker for the dual gpio port
module dgp_gpio_props (
  // clock and register port
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  // pins
  input wire logic [4:0] portAOut,
  input wire logic [4:0] portAOe,
  input wire logic [3:0] analogSel,
  input wire logic [7:0] portBIn,
  input wire logic       extIntPin,
  input wire logic       progData,
  input wire logic [4:0] portAIn,
  input wire logic       firstTimerClk,
  input wire logic       ccpPinLevel,
  input wire logic       progClk,
  input wire logic       wakeReq
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // internal reset lags the pin by two edges
  logic [1:0] upCnt_q;
  logic [1:0] upCnt_d;
  logic       live;
  assign live = (upCnt_q == 2'h3);
  always_comb upCnt_d = live ? upCnt_q : upCnt_q + 2'h1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) upCnt_q <= 2'h0;
    else upCnt_q <= upCnt_d;
  end
  sequence dirWr;
    regWr && regAddr == dgp_pkg::ADDR_A_DIR ##1 !regWr;
  endsequence
  AST_A_DIR: assert property (live ##0 dirWr |-> ##1 portAOe[3:0] == ~$past(regWdata[3:0], 2))
    else $error("drive enable wrong");
  AST_RD_IDLE: assert property (live && !$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not idle");
  AST_OD_LOW: assert property (live |-> !portAOut[dgp_pkg::OD_BIT])
    else $error("open drain high");
  AST_ANA_SEL: assert property (regWr && regAddr == dgp_pkg::ADDR_ANALOG |=> analogSel == $past(regWdata[3:0]))
    else $error("analog select wrong");
  AST_ANA_RD: assert property (regRd && regAddr == dgp_pkg::ADDR_A_DATA |=> (regRdata[3:0] & analogSel) == 4'h0)
    else $error("analog pin not zero");
  AST_WAKE: assert property (live && regRd && regAddr == dgp_pkg::ADDR_INTCTL |=> wakeReq == (regRdata[0] & regRdata[1]))
    else $error("wake wrong");
  AST_EXT_INT: assert property (live |-> extIntPin == $past(portBIn[0]))
    else $error("interrupt pin copy wrong");
  AST_PROG: assert property (live |-> progData == $past(portBIn[7]))
    else $error("programming data wrong");
  AST_T0_CLK: assert property (live |-> firstTimerClk == $past(portAIn[dgp_pkg::OD_BIT]))
    else $error("timer clock copy wrong");
  AST_CCP_LVL: assert property (live |-> ccpPinLevel == $past(portBIn[3]))
    else $error("capture pin copy wrong");
  AST_PROG_CLK: assert property (live |-> progClk == $past(portBIn[6]))
    else $error("programming clock wrong");
endmodule
bind dgp_gpio dgp_gpio_props dgp_gpio_props_i (.clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .portAOut, .portAOe, .analogSel, .portBIn, .extIntPin, .progData, .portAIn, .firstTimerClk, .ccpPinLevel,
  .progClk, .wakeReq);

// >>> sim/tb_top.sv
// self-checking bench for the dual gpio port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWdata = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [4:0]  extA = 5'h1f;
  logic [7:0]  extB = 8'h00;
  logic [7:0]  regRdata, portBOut, portBOe, portBPullup, portBIn;
  logic [4:0]  portAOut, portAOe, portAIn;
  logic        secondTimerClk, wakeReq;
  logic [31:0] seed = 32'h3f22c152;
  logic [31:0] r;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #50 clk = ~clk;
  dgp_gpio dgp_gpio_i (.clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .portAIn, .portAOut,
    .portAOe, .analogSel(), .firstTimerClk(), .portBIn, .portBOut, .portBOe, .portBPullup, .ccpDrive(1'b0),
    .timerOscOut(1'b0), .extIntPin(), .ccpPinLevel(), .secondTimerClk, .progClk(), .progData(), .wakeReq);
  dgp_board dgp_board_i (.portAOut, .portAOe, .portBOut, .portBOe, .portBPullup, .extA, .extB, .portAIn,
    .portBIn);
  // ****************
  // helpers
  // ****************
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // open-drain bit only ever pulls low
  function logic [7:0] expA(logic [4:0] d, logic [4:0] l, logic [3:0] an, logic [4:0] x);
    logic [4:0] p;
    p = (~d & l) | (d & x);
    p[4] = (d[4] | l[4]) ? x[4] : 1'b0;
    return {3'h0, p[4], p[3:0] & ~an};
  endfunction
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rc(input logic [3:0] a, input logic [7:0] e);
    repeat (3) @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, regRdata);
  endtask
  task final_report();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      final_report();
    end
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rc(dgp_pkg::ADDR_A_DIR, {3'h0, dgp_pkg::RST_A_DIR});
    rc(dgp_pkg::ADDR_A_DATA, 8'h10);
    rc(4'hf, 8'h00);
    for (int i = 0; i < 24; i++) begin
      r = (i == 0) ? 32'h0007fe00 : xs();
      wr(dgp_pkg::ADDR_ANALOG, {4'h0, r[3:0]});
      wr(dgp_pkg::ADDR_A_DIR, {3'h0, r[8:4]});
      wr(dgp_pkg::ADDR_A_DATA, {3'h0, r[13:9]});
      extA <= r[18:14];
      rc(dgp_pkg::ADDR_A_DATA, expA(r[8:4], r[13:9], r[3:0], r[18:14]));
    end
    for (int i = 0; i < 12; i++) begin
      r = xs();
      wr(dgp_pkg::ADDR_PULLUP, r[7:0]);
      wr(dgp_pkg::ADDR_B_DIR, r[15:8]);
      wr(dgp_pkg::ADDR_B_DATA, r[23:16]);
      extB <= r[31:24];
      rc(dgp_pkg::ADDR_B_DATA, (~r[15:8] & r[23:16]) | (r[15:8] & (r[7:0] | r[31:24])));
    end
    wr(dgp_pkg::ADDR_B_DIR, 8'hff);
    wr(dgp_pkg::ADDR_PULLUP, 8'h00);
    rc(dgp_pkg::ADDR_B_DATA, extB);
    wr(dgp_pkg::ADDR_INTCTL, 8'h02);
    rc(dgp_pkg::ADDR_INTCTL, 8'h02);
    for (int k = 4; k < 8; k++) begin
      @(posedge clk);
      extB[k] <= ~extB[k];
      rc(dgp_pkg::ADDR_INTCTL, 8'h03);
      chk("wake request", 8'h01, {7'h0, wakeReq});
      wr(dgp_pkg::ADDR_INTCTL, 8'h02);
      rc(dgp_pkg::ADDR_INTCTL, 8'h03);
      rc(dgp_pkg::ADDR_B_DATA, extB);
      wr(dgp_pkg::ADDR_INTCTL, 8'h02);
      rc(dgp_pkg::ADDR_INTCTL, 8'h02);
    end
    @(posedge clk);
    extB[2] <= ~extB[2];
    rc(dgp_pkg::ADDR_INTCTL, 8'h02);
    wr(dgp_pkg::ADDR_B_DIR, 8'h7f);
    wr(dgp_pkg::ADDR_B_DATA, {~extB[7], 7'h00});
    rc(dgp_pkg::ADDR_INTCTL, 8'h02);
    wr(dgp_pkg::ADDR_PERIPH, 8'h28);
    for (int v = 1; v >= 0; v--) begin
      wr(dgp_pkg::ADDR_FWDATA, v[7:0]);
      repeat (3) @(posedge clk);
      #1 chk("timer clock", v[7:0], {7'h0, secondTimerClk});
    end
    wr(dgp_pkg::ADDR_PERIPH, 8'h08);
    for (int v = 0; v < 2; v++) begin
      extB[1] <= v[0];
      repeat (3) @(posedge clk);
      #1 chk("timer pin clock", {7'h0, v[0]}, {7'h0, secondTimerClk});
      @(posedge clk);
    end
    wr(dgp_pkg::ADDR_FWDATA, 8'h01);
    wr(dgp_pkg::ADDR_PERIPH, 8'h20);
    repeat (3) @(posedge clk);
    #1 chk("timer off", 8'h00, {7'h0, secondTimerClk});
    final_report();
  end
endmodule
